/* File: irq_stack_defs.svh */
// Constants for the vector, priority and stack pointer block.
// Assumes a 32-bit Avalon-MM slave port addressed in bytes.
`ifndef IRQ_STACK_DEFS_SVH
`define IRQ_STACK_DEFS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define IDX_SRC_ENABLE 8'h30
`define IDX_SRC_FLAGS 8'h31
`define IDX_CORE_CONTROL 8'h35
`define IDX_EXT_FLAGS 8'h3A
`define IDX_EXT_ENABLE 8'h3B
`define IDX_SP_LOW 8'h3D
`define IDX_SP_HIGH 8'h3E

// ****************************************
// Field positions and reset values
// ****************************************
`define EXT_REQ1_BIT 7
`define EXT_REQ0_BIT 6
`define SENSE0_LSB 0
`define SENSE1_LSB 2
`define SENSE_LEVEL 2'h0
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3
`define SP_RESET 16'h0000
`define REG8_RESET 8'h00
`define SRC_RESET 10'h000

// ****************************************
// Vectors and stack steps
// ****************************************
`define NUM_SOURCES 12
`define VEC_RESET 4'h0
`define VEC_EXT0 4'h1
`define VEC_EXT1 4'h2
`define VEC_FIRST_INTERNAL 3
`define SP_STEP_BYTE 16'h0001
`define SP_STEP_ADDR 16'h0002

`endif

/* File: irq_stack_pkg.sv */
// Types shared by the vector, priority and stack pointer block.
// Assumes the constants header is included by the design file.
package irq_stack_pkg;

    typedef enum logic [4:0] {
        STACK_NONE = 5'h01,
        STACK_PUSH_BYTE = 5'h02,
        STACK_POP_BYTE = 5'h04,
        STACK_PUSH_ADDR = 5'h08,
        STACK_POP_ADDR = 5'h10
    } stack_op_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_ANSWER = 2'h2
    } bus_state_t;

    typedef struct packed {
        logic [1:0] sense1;
        logic [1:0] sense0;
    } sense_cfg_t;

endpackage : irq_stack_pkg

/* File: irq_vector_stack.sv */
// Interrupt vector selection, pending flags, external request sensing
// and the 16-bit stack pointer of an 8-bit core.
// Assumes the core supplies its global enable, vector acknowledges and
// stack steps, and software uses a 32-bit Avalon-MM port with waitrequest.
//
// How it works
// - Twelve interrupt sources plus reset, each with its own vector.
// - A source is taken only with its enable and the global enable set.
// - Vectors 0x000..0x00C: reset, ext0, ext1, then ten internal sources.
// - Lowest pending vector wins; reset first, then external request 0.
// - Flags set while disabled stay set until enabled and served or cleared.
// - Flags wait for the global enable, then serve in priority order.
// - Level-sensed external requests have no flag; pending only while active.
// - Writing one to a flag bit clears it; writing zero does nothing.
// - External enable register: request 1 at bit 7, request 0 at bit 6.
// - External enable register bits 5..0 always read as zero.
// - A two-bit sense field picks rising, falling or level per request.
// - The pin is sensed whatever its direction setting.
// - A request 1 edge sets flag bit 7; taken when both enables set.
// - Request 1 flag clears on vector entry or on a written one.
// - Request 1 flag is held cleared while in level mode.
// - Stack pointer is 16 bits, high byte at 0x3E, low at 0x3D.
// - Stack pointer drops by one per byte push, two per address save.
// - Stack pointer rises by one per byte pop, two per address restore.
`timescale 1ns/1ps
`include "irq_stack_defs.svh"

module irq_vector_stack
    import irq_stack_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic [9:0] ADDRESS_I,
    input wire logic READ_I,
    input wire logic WRITE_I,
    input wire logic [31:0] WRITEDATA_I,
    output logic [31:0] READDATA_O,
    output logic WAITREQUEST_O,
    input wire logic GLOBAL_ENABLE_I,
    input wire logic [1:0] EXT_REQ_PIN_I,
    input wire logic [9:0] SOURCE_EVENT_I,
    input wire logic VECTOR_ACK_I,
    input wire stack_op_t STACK_OP_I,
    output logic IRQ_REQ_O,
    output logic [11:0] IRQ_VECTOR_O,
    output logic [15:0] STACK_POINTER_O
);

    // ****************************************
    // Register bus slave
    // ****************************************
    bus_state_t bus_state;
    logic [7:0] reg_idx;
    logic wr_take;
    logic [7:0] wbyte;
    logic [7:0] ext_enable;
    logic [9:0] src_enable;
    sense_cfg_t sense_cfg;
    logic [`NUM_SOURCES:1] flag;
    logic [15:0] stack_pointer;
    logic [31:0] next_readdata;

    assign reg_idx = ADDRESS_I[9:2];
    assign wbyte = WRITEDATA_I[7:0];
    // Write lands on the edge where waitrequest is seen low
    assign wr_take = WRITE_I && (bus_state == BUS_ANSWER);
    assign WAITREQUEST_O = bus_state[0];

    // One wait cycle per access; request must be held until answered
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            bus_state <= BUS_IDLE;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (READ_I || WRITE_I) begin
                        bus_state <= BUS_ANSWER;
                    end
                end
                BUS_ANSWER: bus_state <= BUS_IDLE;
                default: bus_state <= BUS_IDLE;
            endcase
        end
    end

    always_comb begin
        next_readdata = 32'h00000000;
        case (reg_idx)
            `IDX_SRC_ENABLE: next_readdata[9:0] = src_enable;
            `IDX_SRC_FLAGS: next_readdata[9:0] = flag[`NUM_SOURCES:3];
            `IDX_CORE_CONTROL: next_readdata[3:0] = sense_cfg;
            `IDX_EXT_FLAGS: begin
                next_readdata[`EXT_REQ1_BIT] = flag[2];
                next_readdata[`EXT_REQ0_BIT] = flag[1];
            end
            // Reserved low bits stay zero
            `IDX_EXT_ENABLE: next_readdata[7:6] = ext_enable[7:6];
            `IDX_SP_LOW: next_readdata[7:0] = stack_pointer[7:0];
            `IDX_SP_HIGH: next_readdata[7:0] = stack_pointer[15:8];
            default: next_readdata = 32'h00000000;
        endcase
    end

    // Read data sampled at the request edge, stands through the answer
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            READDATA_O <= 32'h00000000;
        end else if (READ_I && bus_state == BUS_IDLE) begin
            READDATA_O <= next_readdata;
        end
    end

    // ****************************************
    // Enable and sense configuration
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ext_enable <= `REG8_RESET;
            src_enable <= `SRC_RESET;
            sense_cfg <= sense_cfg_t'(4'h0);
        end else if (wr_take) begin
            if (reg_idx == `IDX_EXT_ENABLE) begin
                ext_enable <= {wbyte[7:6], 6'h00};
            end
            if (reg_idx == `IDX_SRC_ENABLE) begin
                src_enable <= WRITEDATA_I[9:0];
            end
            if (reg_idx == `IDX_CORE_CONTROL) begin
                sense_cfg <= sense_cfg_t'(WRITEDATA_I[3:0]);
            end
        end
    end

    // ****************************************
    // External request sensing
    // ****************************************
    // Pins are read straight, so output-driven pins still raise requests
    logic [1:0] pin_prev;
    logic [1:0] ext_edge;
    logic [1:0] ext_level;
    logic [1:0] sense_mode [2];

    assign sense_mode[0] = sense_cfg.sense0;
    assign sense_mode[1] = sense_cfg.sense1;

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            pin_prev <= 2'h3;
        end else begin
            pin_prev <= EXT_REQ_PIN_I;
        end
    end

    genvar e;
    generate
        for (e = 0; e < 2; e++) begin : g_sense
            // Mode 01 is left unused and raises nothing
            assign ext_edge[e] =
                (sense_mode[e] == `SENSE_RISE &&
                 EXT_REQ_PIN_I[e] && !pin_prev[e]) ||
                (sense_mode[e] == `SENSE_FALL &&
                 !EXT_REQ_PIN_I[e] && pin_prev[e]);
            // Low level is the active level
            assign ext_level[e] =
                (sense_mode[e] == `SENSE_LEVEL) && !EXT_REQ_PIN_I[e];
        end
    endgenerate

    // ****************************************
    // Pending flags
    // ****************************************
    logic [`NUM_SOURCES:1] set_ev;
    logic [`NUM_SOURCES:1] w1c;
    logic [`NUM_SOURCES:1] ack_clr;
    logic [`NUM_SOURCES:1] hold_clr;
    logic [`NUM_SOURCES:1] enable;
    logic [`NUM_SOURCES:1] level_req;
    logic [3:0] ack_vec;

    assign ack_vec = IRQ_VECTOR_O[3:0];
    assign set_ev = {SOURCE_EVENT_I, ext_edge[1], ext_edge[0]};
    assign enable = {src_enable, ext_enable[`EXT_REQ1_BIT],
                     ext_enable[`EXT_REQ0_BIT]};
    assign level_req = {10'h000, ext_level};
    assign hold_clr = {10'h000,
                       sense_mode[1] == `SENSE_LEVEL,
                       sense_mode[0] == `SENSE_LEVEL};

    always_comb begin
        w1c = '0;
        if (wr_take && reg_idx == `IDX_EXT_FLAGS) begin
            w1c[2] = wbyte[`EXT_REQ1_BIT];
            w1c[1] = wbyte[`EXT_REQ0_BIT];
        end
        if (wr_take && reg_idx == `IDX_SRC_FLAGS) begin
            w1c[`NUM_SOURCES:3] = WRITEDATA_I[9:0];
        end
    end

    genvar s;
    generate
        for (s = 1; s <= `NUM_SOURCES; s++) begin : g_flag
            // Only a source that is actually served has its flag cleared
            assign ack_clr[s] = VECTOR_ACK_I && IRQ_REQ_O &&
                                (ack_vec == 4'(s));
            always_ff @(posedge CLK_I) begin
                if (!RST_B_I) begin
                    flag[s] <= 1'b0;
                end else if (hold_clr[s]) begin
                    flag[s] <= 1'b0;
                end else if (set_ev[s]) begin
                    // Set wins over a written-one or vector-entry clear in the same cycle; level-mode hold wins over set
                    flag[s] <= 1'b1;
                end else if (w1c[s] || ack_clr[s]) begin
                    flag[s] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************
    // Priority and vector output
    // ****************************************
    logic [`NUM_SOURCES:1] pending;
    logic next_req;
    logic [3:0] next_vec;

    // Flags persist while global enable is off
    assign pending = (flag | level_req) & enable;

    always_comb begin
        next_req = 1'b0;
        next_vec = `VEC_RESET;
        // Descending scan so the lowest vector is the last to win
        for (int i = `NUM_SOURCES; i >= 1; i--) begin
            if (pending[i]) begin
                next_vec = 4'(i);
            end
        end
        next_req = GLOBAL_ENABLE_I && (|pending);
        // An ack consumes the current request; re-evaluate next cycle
        if (VECTOR_ACK_I) begin
            next_req = 1'b0;
        end
    end

    // Reset vector shows while reset is held
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            IRQ_REQ_O <= 1'b0;
            IRQ_VECTOR_O <= 12'h000;
        end else begin
            IRQ_REQ_O <= next_req;
            IRQ_VECTOR_O <= {8'h00, next_vec};
        end
    end

    // ****************************************
    // Stack pointer
    // ****************************************
    // A bus write to a byte takes priority over a stack step that cycle
    logic [15:0] next_sp;

    always_comb begin
        case (STACK_OP_I)
            STACK_NONE: next_sp = stack_pointer;
            STACK_PUSH_BYTE: next_sp = stack_pointer - `SP_STEP_BYTE;
            STACK_POP_BYTE: next_sp = stack_pointer + `SP_STEP_BYTE;
            STACK_PUSH_ADDR: next_sp = stack_pointer - `SP_STEP_ADDR;
            STACK_POP_ADDR: next_sp = stack_pointer + `SP_STEP_ADDR;
            default: next_sp = stack_pointer;
        endcase
        if (wr_take && reg_idx == `IDX_SP_LOW) begin
            next_sp = {stack_pointer[15:8], wbyte};
        end
        if (wr_take && reg_idx == `IDX_SP_HIGH) begin
            next_sp = {wbyte, stack_pointer[7:0]};
        end
    end

    // Software must load a value above 0x60 before use; not checked here
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            stack_pointer <= `SP_RESET;
        end else begin
            stack_pointer <= next_sp;
        end
    end

    assign STACK_POINTER_O = stack_pointer;

    // ****************************************
    // Checks
    // ****************************************
    logic sp_bus_wr;
    assign sp_bus_wr = wr_take &&
        (reg_idx == `IDX_SP_LOW || reg_idx == `IDX_SP_HIGH);

    sp_push_addr_a: assert property (
        @(posedge CLK_I) disable iff (!RST_B_I)
        (STACK_OP_I == STACK_PUSH_ADDR && !sp_bus_wr) |=>
        (stack_pointer == 16'($past(stack_pointer) - 16'h0002)))
        else $error("stack pointer not lowered by two");

    sp_pop_byte_a: assert property (
        @(posedge CLK_I) disable iff (!RST_B_I)
        (STACK_OP_I == STACK_POP_BYTE && !sp_bus_wr) |=>
        (stack_pointer == 16'($past(stack_pointer) + 16'h0001)))
        else $error("stack pointer not raised by one");

    reserved_zero_a: assert property (
        @(posedge CLK_I) disable iff (!RST_B_I)
        (READ_I && bus_state == BUS_IDLE && reg_idx == `IDX_EXT_ENABLE)
        |=> (READDATA_O[5:0] == 6'h00 && !WAITREQUEST_O))
        else $error("reserved enable bits read nonzero");

    global_gate_a: assert property (
        @(posedge CLK_I) disable iff (!RST_B_I)
        !GLOBAL_ENABLE_I |=> !IRQ_REQ_O)
        else $error("request raised with global enable off");

    level_no_flag_a: assert property (
        @(posedge CLK_I) disable iff (!RST_B_I)
        (sense_cfg.sense1 == `SENSE_LEVEL) |=> !flag[2])
        else $error("request 1 flag set in level mode");

    ext0_priority_a: assert property (
        @(posedge CLK_I) disable iff (!RST_B_I)
        (pending[1] && GLOBAL_ENABLE_I && !VECTOR_ACK_I) |=>
        (IRQ_REQ_O && IRQ_VECTOR_O == 12'h001))
        else $error("request 0 not served first");

    flag_w1c_a: assert property (
        @(posedge CLK_I) disable iff (!RST_B_I)
        (wr_take && reg_idx == `IDX_EXT_FLAGS &&
         wbyte[`EXT_REQ1_BIT] && !set_ev[2]) |=> !flag[2])
        else $error("written one did not clear flag");

    edge_sets_a: assert property (
        @(posedge CLK_I) disable iff (!RST_B_I)
        (sense_cfg.sense1 == `SENSE_RISE && EXT_REQ_PIN_I[1] &&
         !pin_prev[1]) |=> flag[2])
        else $error("rising edge did not set flag");

    ack_clears_a: assert property (
        @(posedge CLK_I) disable iff (!RST_B_I)
        (VECTOR_ACK_I && IRQ_REQ_O && IRQ_VECTOR_O == 12'h002 &&
         !set_ev[2]) |=> !flag[2])
        else $error("vector entry did not clear flag");

    bus_answer_a: assert property (
        @(posedge CLK_I) disable iff (!RST_B_I)
        (WAITREQUEST_O && READ_I && reg_idx == `IDX_SP_HIGH) |=>
        (!WAITREQUEST_O && READDATA_O[7:0] == $past(stack_pointer[15:8])))
        else $error("stack pointer high byte misread");

endmodule : irq_vector_stack

/* File: core_model.sv */
// Behavioural core: takes each offered vector and logs its address.
// Assumes registered request and vector outputs and a one-cycle ack.
`timescale 1ns/1ps

module core_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    input wire logic [3:0] delay_i,
    input wire logic irq_req_i,
    input wire logic [11:0] irq_vector_i,
    output logic ack_o
);
    logic [11:0] taken [0:15];
    int taken_n;
    logic [3:0] wait_cnt;

    // ****************************************
    // Vector entry
    // ****************************************
    // Entry stacks no status word; handlers keep it themselves
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            taken_n <= 0;
        end else if (ack_o) begin
            ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            taken[taken_n[3:0]] <= irq_vector_i;
            taken_n <= taken_n + 1;
        end else if (en_i && irq_req_i) begin
            if (wait_cnt >= delay_i) begin
                ack_o <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end else begin
            wait_cnt <= 4'h0;
        end
    end
endmodule : core_model

/* File: irq_vector_and_stack_logic_tb_top.sv */
// Self-checking bench for the vector, flag and stack pointer block.
// Assumes the core model as partner and a 100 MHz clock.
`timescale 1ns/1ps
`include "irq_stack_defs.svh"
`define CHECK_EQ(what, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("wrong value %s exp %0h got %0h", what, exp, got); \
    end \
end

module irq_vector_and_stack_logic_tb_top
    import irq_stack_pkg::*;
();
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [9:0] addr = 10'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic gie = 1'b0;
    logic [1:0] pins = 2'h3;
    logic [9:0] ev = 10'h000;
    logic ack;
    stack_op_t sop = STACK_NONE;
    logic irq;
    logic [11:0] vec;
    logic [15:0] sp;
    logic core_en = 1'b1;
    logic [3:0] delay = 4'h0;
    int bad_count = 0;
    int check_count = 0;
    logic [31:0] q;
    logic [15:0] s;
    logic [9:0] e;
    logic [7:0] cfg;
    int n0;
    int k;
    stack_op_t ops [0:3] = '{STACK_PUSH_ADDR, STACK_POP_ADDR,
        STACK_PUSH_BYTE, STACK_POP_BYTE};
    logic [7:0] idx_tab [0:7] = '{`IDX_SP_LOW, `IDX_SP_HIGH,
        `IDX_EXT_ENABLE, `IDX_EXT_FLAGS, `IDX_SRC_ENABLE, `IDX_SRC_FLAGS,
        `IDX_CORE_CONTROL, 8'h10};

    always #5 clk = ~clk;

    irq_vector_stack dut (.CLK_I(clk), .RST_B_I(rst_b), .ADDRESS_I(addr),
        .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(wdata), .READDATA_O(rdata),
        .WAITREQUEST_O(waitreq), .GLOBAL_ENABLE_I(gie), .EXT_REQ_PIN_I(pins),
        .SOURCE_EVENT_I(ev), .VECTOR_ACK_I(ack), .STACK_OP_I(sop),
        .IRQ_REQ_O(irq), .IRQ_VECTOR_O(vec), .STACK_POINTER_O(sp));

    core_model core (.clk_i(clk), .rst_b_i(rst_b), .en_i(core_en),
        .delay_i(delay), .irq_req_i(irq), .irq_vector_i(vec), .ack_o(ack));

    // ****************************************
    // Tasks and expectations
    // ****************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] idx,
            input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdata <= d;
        rd <= !w;
        wr <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 40);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 40) begin
            bad_count++;
            close_out();
        end
    endtask : bus

    task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask : wr_reg

    task automatic chk_reg(input string nm, input logic [7:0] idx,
            input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, idx, 32'h0, r);
        `CHECK_EQ(nm, exp, r)
    endtask : chk_reg

    task automatic wait_taken(input int want);
        int n;
        n = 0;
        while (core.taken_n != want && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            bad_count++;
            close_out();
        end
    endtask : wait_taken

    function automatic logic [15:0] sp_next(input logic [15:0] v,
            input stack_op_t op);
        case (op)
            STACK_PUSH_BYTE: return v - 16'h0001;
            STACK_POP_BYTE: return v + 16'h0001;
            STACK_PUSH_ADDR: return v - 16'h0002;
            STACK_POP_ADDR: return v + 16'h0002;
            default: return v;
        endcase
    endfunction : sp_next

    // Flags that a falling pin sets under a sense setting
    function automatic logic [31:0] fall_mask(input logic [7:0] c);
        return {24'h0, c[3:2] == `SENSE_FALL, c[1:0] == `SENSE_FALL, 6'h0};
    endfunction : fall_mask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h0CC48851));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            chk_reg("reset value", idx_tab[i], 32'h0);
        end
        wr_reg(8'h10, $urandom);
        chk_reg("unmapped", 8'h10, 32'h0);
        wr_reg(`IDX_EXT_ENABLE, 32'hFF);
        chk_reg("ext enable", `IDX_EXT_ENABLE, 32'hC0);
        $display("test registers done");

        for (int i = 0; i < 8; i++) begin
            s = (i == 0) ? 16'h0000 : 16'($urandom);
            wr_reg(`IDX_SP_LOW, {24'h0, s[7:0]});
            wr_reg(`IDX_SP_HIGH, {24'h0, s[15:8]});
            sop <= ops[i % 4];
            @(posedge clk);
            sop <= STACK_NONE;
            @(posedge clk);
            `CHECK_EQ("sp", sp_next(s, ops[i % 4]), sp)
            s = sp_next(s, ops[i % 4]);
            chk_reg("sp low", `IDX_SP_LOW, {24'h0, s[7:0]});
            chk_reg("sp high", `IDX_SP_HIGH, {24'h0, s[15:8]});
        end
        $display("test stack done");

        wr_reg(`IDX_SP_LOW, 32'h00);
        wr_reg(`IDX_SP_HIGH, 32'h01);
        wr_reg(`IDX_EXT_ENABLE, 32'h00);
        wr_reg(`IDX_SRC_ENABLE, 32'h3FF);
        e = 10'($urandom) | 10'h201;
        delay <= 4'($urandom);
        ev <= e;
        @(posedge clk);
        ev <= 10'h000;
        chk_reg("src flags", `IDX_SRC_FLAGS, {22'h0, e});
        `CHECK_EQ("irq req", 1'b0, irq)
        n0 = core.taken_n;
        gie <= 1'b1;
        wait_taken(n0 + $countones(e));
        k = n0;
        for (int i = 0; i < 10; i++) begin
            if (e[i]) begin
                `CHECK_EQ("vector", 12'(3 + i), core.taken[k])
                k++;
            end
        end
        chk_reg("src flags", `IDX_SRC_FLAGS, 32'h0);
        $display("test internal done");

        wr_reg(`IDX_SRC_ENABLE, 32'h000);
        ev <= 10'h030;
        @(posedge clk);
        ev <= 10'h000;
        repeat (3) @(posedge clk);
        `CHECK_EQ("irq req", 1'b0, irq)
        wr_reg(`IDX_SRC_FLAGS, 32'h000);
        chk_reg("src flags", `IDX_SRC_FLAGS, 32'h030);
        wr_reg(`IDX_SRC_FLAGS, 32'h020);
        chk_reg("src flags", `IDX_SRC_FLAGS, 32'h010);
        n0 = core.taken_n;
        wr_reg(`IDX_SRC_ENABLE, 32'h010);
        wait_taken(n0 + 1);
        `CHECK_EQ("vector", 12'h007, core.taken[n0])
        $display("test masked done");

        for (int r = 0; r < 2; r++) begin
            cfg = (r == 0) ? 8'h0B : 8'h0E;
            gie <= 1'b0;
            wr_reg(`IDX_CORE_CONTROL, {24'h0, cfg});
            wr_reg(`IDX_EXT_ENABLE, 32'hC0);
            pins <= 2'h0;
            repeat (2) @(posedge clk);
            chk_reg("ext flags", `IDX_EXT_FLAGS, fall_mask(cfg));
            pins <= 2'h3;
            repeat (2) @(posedge clk);
            chk_reg("ext flags", `IDX_EXT_FLAGS, 32'hC0);
            if (r == 0) begin
                n0 = core.taken_n;
                gie <= 1'b1;
                wait_taken(n0 + 2);
                `CHECK_EQ("vector", 12'(`VEC_EXT0), core.taken[n0])
                `CHECK_EQ("vector", 12'(`VEC_EXT1), core.taken[n0 + 1])
                chk_reg("ext flags", `IDX_EXT_FLAGS, 32'h0);
            end else begin
                wr_reg(`IDX_EXT_FLAGS, 32'h00);
                chk_reg("ext flags", `IDX_EXT_FLAGS, 32'hC0);
                wr_reg(`IDX_EXT_FLAGS, 32'h40);
                chk_reg("ext flags", `IDX_EXT_FLAGS, 32'h80);
                wr_reg(`IDX_EXT_FLAGS, 32'h80);
                chk_reg("ext flags", `IDX_EXT_FLAGS, 32'h00);
            end
        end
        $display("test edges done");

        core_en <= 1'b0;
        gie <= 1'b1;
        wr_reg(`IDX_CORE_CONTROL, 32'h00);
        wr_reg(`IDX_EXT_ENABLE, 32'h40);
        pins <= 2'h0;
        repeat (3) @(posedge clk);
        `CHECK_EQ("irq req", 1'b1, irq)
        `CHECK_EQ("vector", 12'h001, vec)
        chk_reg("ext flags", `IDX_EXT_FLAGS, 32'h0);
        pins <= 2'h3;
        repeat (3) @(posedge clk);
        `CHECK_EQ("irq req", 1'b0, irq)
        wr_reg(`IDX_CORE_CONTROL, 32'h05);
        wr_reg(`IDX_EXT_ENABLE, 32'hC0);
        pins <= 2'h0;
        repeat (3) @(posedge clk);
        `CHECK_EQ("irq req", 1'b0, irq)
        chk_reg("ext flags", `IDX_EXT_FLAGS, 32'h0);
        $display("test level done");
        close_out();
    end
endmodule : irq_vector_and_stack_logic_tb_top
